// >>> logic/flash_seq_map.vh
// Constants for the serial flash command sequencer
// Behaviour
// RULE1: Block erase clears addressed 64K block to ones
// RULE2: Block erase needs opcode, three address bytes
// RULE3: Opcode eight clocks single, two clocks quad
// RULE4: Erase busy flag high, latch cleared, protection honoured
// RULE5: Full erase only when protection bits zero
// RULE6: Full erase opcode only, ends on boundary
// RULE7: Page write keeps final 256 data bytes
// RULE8: Page write wraps within page past end
// RULE9: Short page write leaves other bytes unchanged
// RULE10: Page write needs data, ends on byte
// RULE11: Program busy flag high, latch cleared, protection honoured
// RULE12: Host arms latch, quad allow before quad write
// RULE13: Host slows clock for quad page write
// RULE14: Deep sleep ignores all but release, signature, reset
// RULE15: Sleep entry on boundary after entry delay
// RULE16: Soft reset or power-up leaves deep sleep
// RULE17: Release waits wake delay when asleep
// RULE18: Release and signature refused while busy
// RULE19: Signature repeats while clocks continue
// RULE20: Maker and part read single line, MSB first
// RULE21: Address 01h swaps order, codes alternate
// RULE22: Erase or program ignored without write arm
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH
`define OP_WRITE_ARM 8'h06
`define OP_BLOCK_ERASE 8'hD8
`define OP_FULL_ERASE_A 8'h60
`define OP_FULL_ERASE_B 8'hC7
`define OP_PAGE_WRITE 8'h02
`define OP_QUAD_PAGE_WRITE 8'h38
`define OP_SLEEP_ENTRY 8'hB9
`define OP_SLEEP_RELEASE 8'hAB
`define OP_MAKER_PART 8'h90
`define OP_RESET_ARM 8'h66
`define OP_RESET_GO 8'h99
`define PAGE_BYTES 256
`define CLK_NS 100
`define BLOCK_ERASE_TIME_NS 20000
`define FULL_ERASE_TIME_NS 100000
`define PAGE_WRITE_TIME_NS 5000
`define SLEEP_ENTRY_DELAY_NS 10000
`define WAKE_DELAY_NS 30000
`define SIG_CODE 8'h5A
`define MAKER_CODE 8'hA5
`define PART_CODE 8'h5A
`endif

// >>> logic/sync2.v
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module sync2
(
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_async,
    output wire o_sync
);
    reg meta_q;
    reg sync_q;
    // First stage is read only by the second
    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule

// >>> logic/flash_seq.v
// Serial flash command sequencer: erase, program, sleep and ID reads
`timescale 1ns/1ps
`include "flash_seq_map.vh"
module flash_seq
#(
    parameter BLOCK_ERASE_CYC = (`BLOCK_ERASE_TIME_NS + `CLK_NS - 1) / `CLK_NS,
    parameter FULL_ERASE_CYC = (`FULL_ERASE_TIME_NS + `CLK_NS - 1) / `CLK_NS,
    parameter PAGE_WRITE_CYC = (`PAGE_WRITE_TIME_NS + `CLK_NS - 1) / `CLK_NS,
    parameter SLEEP_ENTRY_CYC = (`SLEEP_ENTRY_DELAY_NS + `CLK_NS - 1) / `CLK_NS,
    parameter WAKE_CYC = `WAKE_DELAY_NS / `CLK_NS
)
(
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_chip_select_n,
    input wire i_sclk,
    input wire [3:0] i_quad_io_lines,
    output reg [3:0] o_quad_io_lines,
    output reg [3:0] o_quad_io_oe_n,
    input wire i_quad_cmd_mode,
    input wire i_quad_io_allow,
    input wire [3:0] i_protect_level_bits,
    output wire o_op_in_progress_flag,
    output wire o_write_arm_latch,
    output wire o_deep_sleep,
    output reg o_erase_go,
    output reg o_erase_full,
    output reg [7:0] o_erase_block,
    output reg o_prog_go,
    output reg [23:0] o_prog_page_addr,
    output reg [7:0] o_prog_rd_idx,
    input wire [7:0] i_prog_rd_idx,
    output reg [7:0] o_prog_rd_data,
    output reg o_prog_rd_valid
);
    // ****************************************
    // Timer loads
    // ****************************************
    // Sized to the countdown register so every load is an exact fit
    // Counts above 24 bits would not fit; the defaults stay far below that
    localparam [23:0] BLOCK_ERASE_T = BLOCK_ERASE_CYC;
    localparam [23:0] FULL_ERASE_T = FULL_ERASE_CYC;
    localparam [23:0] PAGE_WRITE_T = PAGE_WRITE_CYC;
    localparam [23:0] SLEEP_ENTRY_T = SLEEP_ENTRY_CYC;
    localparam [23:0] WAKE_T = WAKE_CYC;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire cs_n_s;
    wire sclk_s;
    wire [3:0] io_s;
    // Select goes through inverted, so the flops' reset value is the idle pin
    // and no false select edge follows reset
    wire [5:0] pin_raw = {~i_chip_select_n, i_sclk, i_quad_io_lines};
    wire [5:0] pin_s;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : g_sync
            sync2 u_sync
            (
                .i_clk_sys(i_clk_sys),
                .i_srst(i_srst),
                .i_async(pin_raw[g]),
                .o_sync(pin_s[g])
            );
        end
    endgenerate
    assign cs_n_s = ~pin_s[5];
    assign sclk_s = pin_s[4];
    assign io_s = pin_s[3:0];

    // Commands still taken while the sleep state holds
    function sleep_ok;
        input [7:0] op;
        begin
            sleep_ok = (op == `OP_SLEEP_RELEASE) || (op == `OP_RESET_ARM) ||
                (op == `OP_RESET_GO);
        end
    endfunction

    // ****************************************
    // Edge detect and bit counting
    // ****************************************
    reg cs_n_q, sclk_q;
    wire sclk_rise = sclk_s & ~sclk_q & ~cs_n_s;
    wire sclk_fall = ~sclk_s & sclk_q & ~cs_n_s;
    wire cs_fall = ~cs_n_s & cs_n_q;
    wire cs_rise = cs_n_s & ~cs_n_q;
    reg [12:0] bits_q;          // Bits taken this frame
    reg [7:0] sh_q;             // Byte shift register
    reg [7:0] op_q;
    reg [23:0] addr_q;
    reg [8:0] dcount_q;         // Data bytes taken, saturates at a page
    reg quad_q;                 // Current frame runs four lines wide
    reg [7:0] buf_q [0:255];
    reg [7:0] widx_q;
    reg wel_q, busy_q, sleep_q, reset_armed_q;
    reg [23:0] timer_q;
    reg [1:0] tkind_q;          // 0 none, 1 erase, 2 program, 3 sleep/wake
    reg wake_pend_q, sleep_pend_q;
    reg [7:0] out_sh_q;
    reg out_en_q, swap_q;
    reg [2:0] out_bit_q;

    wire [3:0] step = quad_q ? 4'd4 : 4'd1;
    wire [12:0] bits_n = bits_q + {9'd0, step};
    wire [7:0] sh_n = quad_q ? {sh_q[3:0], io_s} : {sh_q[6:0], io_s[0]};
    wire byte_done = sclk_rise & (bits_n[2:0] == 3'd0);
    // Wide enough that a page write frame of up to 1024 bytes never aliases onto address bytes
    wire [9:0] nbyte = bits_q[12:3];
    wire on_boundary = (bits_q[2:0] == 3'd0);
    wire prot = |i_protect_level_bits;
    wire [8:0] room_d = (dcount_q == 9'd256) ? 9'd256 : dcount_q + 9'd1;

    // Output data on falling edges, MSB first
    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_quad_io_lines <= 4'h0;
            o_quad_io_oe_n <= 4'hF;
            out_bit_q <= 3'd0;
            swap_q <= 1'b0;
        end
        else if (cs_n_s)
        begin
            o_quad_io_oe_n <= 4'hF;
            out_bit_q <= 3'd0;
        end
        else if (sclk_fall && out_en_q)
        begin
            o_quad_io_oe_n <= 4'hD;
            o_quad_io_lines <= {2'b00, out_sh_q[~out_bit_q], 1'b0}; // RULE20
            out_bit_q <= out_bit_q + 3'd1;
            if (out_bit_q == 3'd7)
                swap_q <= ~swap_q; // RULE21
        end
        else if (cs_fall)
            swap_q <= 1'b0;
    end

    // ****************************************
    // Command decode and self-timed cycles
    // ****************************************
    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            bits_q <= 13'd0;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            addr_q <= 24'h0;
            dcount_q <= 9'd0;
            quad_q <= 1'b0;
            widx_q <= 8'h00;
            wel_q <= 1'b0;
            busy_q <= 1'b0;
            sleep_q <= 1'b0; // RULE16
            reset_armed_q <= 1'b0;
            timer_q <= 24'd0;
            tkind_q <= 2'd0;
            wake_pend_q <= 1'b0;
            sleep_pend_q <= 1'b0;
            out_sh_q <= 8'h00;
            out_en_q <= 1'b0;
            o_erase_go <= 1'b0;
            o_erase_full <= 1'b0;
            o_erase_block <= 8'h00;
            o_prog_go <= 1'b0;
            o_prog_page_addr <= 24'h0;
        end
        else
        begin
            cs_n_q <= cs_n_s;
            sclk_q <= sclk_s;
            o_erase_go <= 1'b0;
            o_prog_go <= 1'b0;
            if (cs_fall)
            begin
                bits_q <= 13'd0;
                dcount_q <= 9'd0;
                out_en_q <= 1'b0;
                quad_q <= i_quad_cmd_mode; // RULE3
            end
            if (sclk_rise)
            begin
                bits_q <= bits_n;
                sh_q <= sh_n;
            end
            if (byte_done)
            begin
                if (nbyte == 10'd0)
                begin
                    op_q <= sh_n;
                    if (sh_n == `OP_QUAD_PAGE_WRITE && i_quad_io_allow)
                        quad_q <= 1'b1;
                    if (sh_n == `OP_SLEEP_RELEASE && !busy_q)
                    begin
                        out_sh_q <= `SIG_CODE; // RULE19
                        out_en_q <= 1'b1;
                    end
                end
                else if (nbyte <= 10'd3)
                    addr_q <= {addr_q[15:0], sh_n};
                else if (op_q == `OP_PAGE_WRITE || op_q == `OP_QUAD_PAGE_WRITE)
                begin
                    // Index wraps in the page, later bytes overwrite earlier
                    buf_q[widx_q] <= sh_n; // RULE7 RULE8
                    widx_q <= widx_q + 8'd1;
                    dcount_q <= room_d; // RULE9
                end
                if (nbyte == 10'd3)
                begin
                    widx_q <= sh_n;
                    if (op_q == `OP_MAKER_PART && !quad_q && !sleep_q)
                    begin
                        out_en_q <= 1'b1;
                        out_sh_q <= (sh_n == 8'h01) ? `PART_CODE : `MAKER_CODE; // RULE21
                    end
                end
            end
            if (out_en_q && op_q == `OP_MAKER_PART && out_bit_q == 3'd0)
                out_sh_q <= ((addr_q[7:0] == 8'h01) ^ swap_q) ? `PART_CODE : `MAKER_CODE;
            if (cs_rise && on_boundary && !busy_q)
            begin
                reset_armed_q <= 1'b0;
                case (op_q)
                    `OP_WRITE_ARM:
                        if (!sleep_q && nbyte == 10'd1)
                            wel_q <= 1'b1;
                    `OP_BLOCK_ERASE:
                        if (!sleep_q && wel_q && nbyte == 10'd4 && !prot) // RULE2 RULE22
                        begin
                            busy_q <= 1'b1; // RULE4
                            tkind_q <= 2'd1;
                            timer_q <= BLOCK_ERASE_T;
                            o_erase_go <= 1'b1; // RULE1
                            o_erase_full <= 1'b0;
                            o_erase_block <= addr_q[23:16];
                        end
                    `OP_FULL_ERASE_A, `OP_FULL_ERASE_B:
                        if (!sleep_q && wel_q && nbyte == 10'd1 && !prot) // RULE5 RULE6
                        begin
                            busy_q <= 1'b1;
                            tkind_q <= 2'd1;
                            timer_q <= FULL_ERASE_T;
                            o_erase_go <= 1'b1;
                            o_erase_full <= 1'b1;
                        end
                    `OP_PAGE_WRITE, `OP_QUAD_PAGE_WRITE:
                        if (!sleep_q && wel_q && nbyte >= 10'd5 && !prot) // RULE10 RULE22
                        begin
                            busy_q <= 1'b1; // RULE11
                            tkind_q <= 2'd2;
                            timer_q <= PAGE_WRITE_T;
                            o_prog_go <= 1'b1;
                            o_prog_page_addr <= addr_q;
                        end
                    `OP_SLEEP_ENTRY:
                        if (!sleep_q && nbyte == 10'd1) // RULE15
                        begin
                            sleep_pend_q <= 1'b1;
                            tkind_q <= 2'd3;
                            timer_q <= SLEEP_ENTRY_T;
                        end
                    `OP_SLEEP_RELEASE:
                        if (sleep_q) // RULE17 RULE18
                        begin
                            wake_pend_q <= 1'b1;
                            tkind_q <= 2'd3;
                            timer_q <= WAKE_T;
                        end
                    `OP_RESET_ARM:
                        reset_armed_q <= 1'b1;
                    `OP_RESET_GO:
                        // A pending sleep entry is dropped too, or it would re-enter sleep
                        if (reset_armed_q)
                        begin
                            sleep_q <= 1'b0; // RULE16
                            wel_q <= 1'b0;
                            sleep_pend_q <= 1'b0;
                            wake_pend_q <= 1'b0;
                            tkind_q <= 2'd0;
                        end
                    default:
                        reset_armed_q <= 1'b0;
                endcase
                if (sleep_q && !sleep_ok(op_q))
                    reset_armed_q <= 1'b0; // RULE14
            end
            // Countdown of the running timed action
            if (tkind_q != 2'd0)
            begin
                if (timer_q <= 24'd1)
                begin
                    tkind_q <= 2'd0;
                    if (busy_q)
                    begin
                        busy_q <= 1'b0;
                        wel_q <= 1'b0; // RULE4 RULE6 RULE11
                    end
                    if (sleep_pend_q)
                        sleep_q <= 1'b1;
                    if (wake_pend_q)
                        sleep_q <= 1'b0;
                    sleep_pend_q <= 1'b0;
                    wake_pend_q <= 1'b0;
                end
                else
                    timer_q <= timer_q - 24'd1;
            end
        end
    end

    // Program buffer read port for the array side
    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_prog_rd_idx <= 8'h00;
            o_prog_rd_data <= 8'h00;
            o_prog_rd_valid <= 1'b0;
        end
        else
        begin
            o_prog_rd_idx <= i_prog_rd_idx;
            o_prog_rd_data <= buf_q[i_prog_rd_idx];
            // Bytes never received keep the page unchanged
            o_prog_rd_valid <= ({1'b0, i_prog_rd_idx - o_prog_page_addr[7:0]} < dcount_q);
        end
    end

    assign o_op_in_progress_flag = busy_q;
    assign o_write_arm_latch = wel_q;
    assign o_deep_sleep = sleep_q;
endmodule

// >>> testbench/flash_seq_asserts.sv
// Concurrent checks on the flash sequencer ports
`timescale 1ns/1ps
module flash_seq_asserts
#(
    parameter FULL_ERASE_CYC = 1000
)
(
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_chip_select_n,
    input wire [3:0] i_protect_level_bits,
    input wire o_op_in_progress_flag,
    input wire o_write_arm_latch,
    input wire o_deep_sleep,
    input wire o_erase_go,
    input wire o_prog_go,
    input wire [3:0] o_quad_io_oe_n
);
    // ********************
    // Checks
    // ********************
    // ********************
    logic [31:0] busy_cnt_q;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    sequence s_go;
        o_erase_go || o_prog_go;
    endsequence
    sequence s_cs_idle;
        i_chip_select_n [*6];
    endsequence
    // Length of the current busy stretch; a stuck timer shows up here
    always @(posedge i_clk_sys)
        if (i_srst || !o_op_in_progress_flag)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    a_go_sets_busy: assert property (s_go |-> ##[0:2] o_op_in_progress_flag)
        else $error("busy flag missing after start");
    a_go_one_cycle: assert property (s_go |=> !o_erase_go && !o_prog_go)
        else $error("start pulse longer than one cycle");
    a_go_armed: assert property (s_go |-> o_write_arm_latch || $past(o_write_arm_latch))
        else $error("start without arm latch");
    a_go_unprot: assert property (s_go |-> i_protect_level_bits == 4'h0)
        else $error("start while protected");
    a_go_cs_high: assert property (s_go |-> i_chip_select_n)
        else $error("start while selected");
    a_sleep_quiet: assert property (o_deep_sleep |-> !o_erase_go && !o_prog_go)
        else $error("start while asleep");
    a_sleep_no_arm: assert property ($rose(o_write_arm_latch) |-> !$past(o_deep_sleep))
        else $error("arm latch set while asleep");
    a_end_clears_wel: assert property ($fell(o_op_in_progress_flag) |-> ##[0:1] !o_write_arm_latch)
        else $error("arm latch kept after cycle");
    a_busy_bounded: assert property (busy_cnt_q <= FULL_ERASE_CYC + 4)
        else $error("busy for too long");
    a_idle_oe_off: assert property (s_cs_idle |-> o_quad_io_oe_n == 4'hF)
        else $error("output driven while deselected");
    a_oe_one_line: assert property (o_quad_io_oe_n == 4'hF || o_quad_io_oe_n == 4'hD)
        else $error("readout on a line other than serial out");
endmodule

bind flash_seq flash_seq_asserts #(.FULL_ERASE_CYC(FULL_ERASE_CYC)) i_asserts
(
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_chip_select_n(i_chip_select_n),
    .i_protect_level_bits(i_protect_level_bits),
    .o_op_in_progress_flag(o_op_in_progress_flag),
    .o_write_arm_latch(o_write_arm_latch),
    .o_deep_sleep(o_deep_sleep),
    .o_erase_go(o_erase_go),
    .o_prog_go(o_prog_go),
    .o_quad_io_oe_n(o_quad_io_oe_n)
);

// >>> testbench/host_model.sv
// Host controller model driving the serial flash pins
`timescale 1ns/1ps
module host_model
(
    input wire i_clk_sys,
    input wire [3:0] i_io,
    output logic o_cs_n,
    output logic o_sclk,
    output logic [3:0] o_io
);
    // ********************
    // Frames
    // ********************
    integer seed = 32'hb2953eaf;
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_io = 4'h0;
    end
    // One byte MSB first; 4 low plus 4 high cycles keeps the clock at 800 ns
    task automatic xfer(input logic [7:0] b, input logic quad, output logic [7:0] rx);
        integer i;
        rx = 8'h00;
        for (i = 0; i < (quad ? 2 : 8); i++)
        begin
            @(posedge i_clk_sys);
            o_sclk <= 1'b0;
            o_io <= quad ? (i ? b[3:0] : b[7:4]) : {3'($random(seed)), b[7 - i]};
            repeat (4) @(posedge i_clk_sys);
            o_sclk <= 1'b1;
            repeat (3) @(posedge i_clk_sys);
            rx = {rx[6:0], i_io[1]}; // Sampled late in the high phase, output settled
        end
    endtask
    // Whole frame; cs rises on the byte boundary and stays high for 24 cycles
    task automatic frame(input logic [7:0] q[$], input logic quad, output logic [7:0] rx);
        integer j;
        @(posedge i_clk_sys);
        o_cs_n <= 1'b0;
        for (j = 0; j < q.size(); j++)
            xfer(q[j], quad, rx);
        @(posedge i_clk_sys);
        o_sclk <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        o_cs_n <= 1'b1;
        o_io <= ~o_io; // Released lines must not hold the last value
        repeat (24) @(posedge i_clk_sys);
    endtask
endmodule

// >>> testbench/flash_seq_tb.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "flash_seq_map.vh"
module flash_seq_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic quad_mode = 1'b0;
    logic [3:0] prot = 4'h0;
    logic qio_allow = 1'b0;
    logic [7:0] rd_idx = 8'h00;
    logic [7:0] rx;
    logic [31:0] exp_q[$];
    wire cs_n, sclk, busy, write_arm_latch, sleep, e_go, e_full, p_go, p_valid;
    wire [3:0] host_io, dev_io, dev_oe_n, line;
    wire [7:0] e_blk, p_idx, p_data;
    wire [23:0] p_addr;
    integer error_cnt = 0;
    integer n_compared = 0;
    integer k;
    always #50 clk_sys = ~clk_sys;
    // Wire level: device wins where its enable is low
    assign line = (dev_oe_n & host_io) | (~dev_oe_n & dev_io);
    flash_seq #(.BLOCK_ERASE_CYC(5), .FULL_ERASE_CYC(5), .PAGE_WRITE_CYC(5)) i_dut
    (
        .i_clk_sys(clk_sys), .i_srst(srst), .i_chip_select_n(cs_n), .i_sclk(sclk),
        .i_quad_io_lines(line), .o_quad_io_lines(dev_io), .o_quad_io_oe_n(dev_oe_n),
        .i_quad_cmd_mode(quad_mode), .i_quad_io_allow(qio_allow), .i_protect_level_bits(prot),
        .o_op_in_progress_flag(busy), .o_write_arm_latch(write_arm_latch), .o_deep_sleep(sleep),
        .o_erase_go(e_go), .o_erase_full(e_full), .o_erase_block(e_blk), .o_prog_go(p_go),
        .o_prog_page_addr(p_addr), .o_prog_rd_idx(p_idx), .i_prog_rd_idx(rd_idx),
        .o_prog_rd_data(p_data), .o_prog_rd_valid(p_valid)
    );
    host_model i_host
    (
        .i_clk_sys(clk_sys), .i_io(line), .o_cs_n(cs_n), .o_sclk(sclk), .o_io(host_io)
    );
    // ********************
    // Checking
    // ********************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Each start pulse takes the oldest note; an unplanned start meets all ones
    always @(posedge clk_sys)
        if (!srst && (e_go || p_go))
            check(e_go ? {8'hE0, 15'h0, e_full, e_full ? 8'h00 : e_blk} : {8'hB0, p_addr},
                exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF);
    initial
    begin
        #2000000;
        error_cnt++;
        end_sim();
    end
    // ********************
    // Scenarios
    // ********************
    initial
    begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({busy, write_arm_latch, sleep, dev_oe_n}, 7'h0F);
        i_host.frame('{`OP_PAGE_WRITE, 8'h00, 8'h12, 8'h34, 8'h55}, 1'b0, rx);
        check({busy, write_arm_latch}, 2'b00);
        i_host.frame('{`OP_WRITE_ARM}, 1'b0, rx);
        check(write_arm_latch, 1'b1);
        exp_q.push_back({8'hB0, 24'h0312FE});
        i_host.frame('{`OP_PAGE_WRITE, 8'h03, 8'h12, 8'hFE, 8'h11, 8'h22, 8'h33}, 1'b0, rx);
        check({busy, write_arm_latch}, 2'b00);
        // Three bytes from FEh run past the page end, the third wrapping to 00h; the next byte stays untouched
        for (k = 0; k < 4; k++)
        begin
            @(posedge clk_sys);
            rd_idx <= 8'hFE + k[7:0];
            repeat (3) @(posedge clk_sys);
            check({p_valid, p_idx}, {k < 3, 8'hFE + k[7:0]});
            if (k < 3)
                check(p_data, 8'h11 * (k + 1));
        end
        i_host.frame('{`OP_WRITE_ARM}, 1'b0, rx);
        i_host.frame('{`OP_BLOCK_ERASE, 8'h07, 8'h00}, 1'b0, rx);
        check(write_arm_latch, 1'b1);
        quad_mode <= 1'b1;
        exp_q.push_back(32'hE0000007);
        i_host.frame('{`OP_BLOCK_ERASE, 8'h07, 8'hAB, 8'hCD}, 1'b1, rx);
        check({busy, write_arm_latch}, 2'b00);
        quad_mode <= 1'b0;
        prot <= 4'h2;
        i_host.frame('{`OP_WRITE_ARM}, 1'b0, rx);
        i_host.frame('{`OP_FULL_ERASE_A}, 1'b0, rx);
        check(write_arm_latch, 1'b1);
        prot <= 4'h0;
        exp_q.push_back(32'hE0000100);
        exp_q.push_back(32'hE0000100);
        i_host.frame('{`OP_FULL_ERASE_A}, 1'b0, rx);
        i_host.frame('{`OP_WRITE_ARM}, 1'b0, rx);
        i_host.frame('{`OP_FULL_ERASE_B}, 1'b0, rx);
        check({busy, write_arm_latch}, 2'b00);
        i_host.frame('{`OP_SLEEP_ENTRY}, 1'b0, rx);
        repeat (`SLEEP_ENTRY_DELAY_NS / `CLK_NS) @(posedge clk_sys);
        check(sleep, 1'b1);
        i_host.frame('{`OP_WRITE_ARM}, 1'b0, rx);
        check(write_arm_latch, 1'b0);
        i_host.frame('{`OP_SLEEP_RELEASE}, 1'b0, rx);
        repeat (`WAKE_DELAY_NS / `CLK_NS) @(posedge clk_sys);
        check(sleep, 1'b0);
        i_host.frame('{`OP_SLEEP_RELEASE, 8'h00, 8'h00}, 1'b0, rx);
        check(rx, `SIG_CODE);
        i_host.frame('{`OP_MAKER_PART, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00}, 1'b0, rx);
        check(rx, `MAKER_CODE);
        i_host.frame('{`OP_SLEEP_ENTRY}, 1'b0, rx);
        repeat (`SLEEP_ENTRY_DELAY_NS / `CLK_NS) @(posedge clk_sys);
        i_host.frame('{`OP_RESET_ARM}, 1'b0, rx);
        i_host.frame('{`OP_RESET_GO}, 1'b0, rx);
        check(sleep, 1'b0);
        check(exp_q.size(), 0);
        end_sim();
    end
endmodule
